// File: inc/rpx_map.vh
// Purpose: Register map, field layout and timing constants for the remote
//          point exchange block.
// Assumes: APB byte addresses, 32-bit words, 100 MHz pclk.
// Notes:   Definitions only.
`ifndef RPX_MAP_VH
`define RPX_MAP_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define RPX_ID_BASE 12'h000
`define RPX_ID_END 12'h140
`define RPX_RIN_BASE 12'h200
`define RPX_TXSEL_BASE 12'h300
`define RPX_LOGEN 12'h340
`define RPX_INTERVAL 12'h344
`define RPX_CTRL 12'h348
`define RPX_RSTSEL 12'h34C
`define RPX_ONLINE 12'h350
`define RPX_RIN_VAL 12'h354
`define RPX_RIN_KNOWN 12'h358
`define RPX_DIRSRC_BASE 12'h380

// ----------------------------------------------------------------------
// Sizes and field positions
// ----------------------------------------------------------------------
`define RPX_SLOTS 16
`define RPX_ID_WORDS 5
`define RPX_ID_BITS 160
`define RPX_POINTS 32
`define RPX_RIN_DEV_LSB 0
`define RPX_RIN_PAIR_LSB 4
`define RPX_RIN_MODE_LSB 10
`define RPX_CTRL_COMMS_RST 0

// Fallback modes
`define RPX_MODE_OFF 2'h0
`define RPX_MODE_ON 2'h1
`define RPX_MODE_LATEST_OFF 2'h2
`define RPX_MODE_LATEST_ON 2'h3

// Transmitted standard point positions (zero based)
`define RPX_DNA_OPERDEV 0
`define RPX_DNA_BKR_3PH 13
`define RPX_DNA_BKR_PHC 16
`define RPX_DNA_STATUS 20
`define RPX_DNA_MODE 26

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define RPX_INTERVAL_RST 16'h03E8
`define RPX_HOLD_FACTOR 3
`define RPX_MS_NS 1000000
`define RPX_CLK_NS 10

`endif

// File: hdl/rpx_remote_point_exchange.v
// Purpose: Binary point exchange with peer relays: receive filtering,
//          remote inputs with fallback, periodic transmit, latch reset,
//          direct input source selection.
// Assumes: Message framing is done outside; one decoded message per
//          msg_valid cycle. All inputs synchronous to pclk.
// Notes:   Registers reached over APB with zero wait states.
//
// Behaviour
// - Sixteen peer slots with 20-character identifiers
// - Accept message only on exact identifier match
// - 32 remote inputs from 64 point choices
// - Each remote input selects its peer slot
// - Each remote input selects its bit pair
// - Fallback after startup and peer offline
// - Mode On forces 1, Off forces 0
// - Latest/On freezes, unknown reads 1
// - Latest/Off freezes, unknown reads 0
// - Resumed messages make input follow again
// - 32 standard points with operand and logging
// - Points 14-17: 0 open, 1 closed
// - Point 21: 0 offline, 1 available
// - Point 27: 0 normal, 1 test
// - 32 user points from selected operands
// - Resend message after interval without change
// - Indicator latches hold until reset command
// - Three reset sources, common and source pulses
// - Reset clears only absent conditions; pulses logged
// - Direct inputs follow their configured source peer
// - Per-peer hold timer, offline on expiry
// - Sent hold time is three intervals
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "rpx_map.vh"

module rpx_remote_point_exchange #(
  parameter MS_CYCLES = `RPX_MS_NS / `RPX_CLK_NS
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire msg_valid,
  input wire [159:0] msg_origin_id,
  input wire [63:0] msg_dna,
  input wire [63:0] msg_user,
  input wire [15:0] msg_hold_ms,
  output reg [31:0] remote_in_q,
  input wire [63:0] local_operand,
  output reg [31:0] tx_dna_q,
  output reg [31:0] tx_user_q,
  output reg [17:0] tx_hold_ms_q,
  output reg tx_send_q,
  output reg [31:0] dna_event_q,
  input wire panel_button,
  input wire [31:0] latch_cond,
  output reg [31:0] latched_flag_q,
  output reg common_reset_pulse_q,
  output reg panel_reset_pulse_q,
  output reg link_reset_pulse_q,
  output reg logic_reset_pulse_q,
  input wire dir_valid,
  input wire [7:0] dir_peer,
  input wire [31:0] dir_bits,
  output reg [31:0] direct_in_q
);
  localparam [31:0] MS_FULL = MS_CYCLES - 1;
  localparam [16:0] MS_LAST = MS_FULL[16:0];

  // ----------------------------------------------------------------------
  // Configuration storage
  // ----------------------------------------------------------------------
  reg [31:0] peer_slot_identifier_q [0:79];
  reg [11:0] rin_cfg_q [0:31];
  reg [31:0] standard_point_source_q [0:15];
  reg [31:0] direct_input_source_peer_q [0:7];
  reg [31:0] standard_point_log_enable_q, known_q, last_q, rd_d;
  reg [15:0] interval_q, online_q, int_cnt_q;
  reg [16:0] ms_cnt_q;
  reg [5:0] reset_sel_q;
  reg ms_tick_q, boot_q, panel_prev_q, oper_prev_q, comms_req_q, err_d;
  integer k;
  wire [11:0] a = paddr;
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pwrite & pready;

  // ----------------------------------------------------------------------
  // APB read decode
  // ----------------------------------------------------------------------
  // Decoded in setup so prdata is a flop and ready in the access cycle
  always @* begin
    rd_d = 32'h0000_0000;
    err_d = 1'b0;
    if (a < `RPX_ID_END) begin
      rd_d = peer_slot_identifier_q[a[8:2]];
    end else if (a[11:7] == `RPX_RIN_BASE >> 7) begin
      rd_d = {20'h0_0000, rin_cfg_q[a[6:2]]};
    end else if (a[11:6] == `RPX_TXSEL_BASE >> 6) begin
      rd_d = standard_point_source_q[a[5:2]];
    end else if (a == `RPX_LOGEN) begin
      rd_d = standard_point_log_enable_q;
    end else if (a == `RPX_INTERVAL) begin
      rd_d = {16'h0000, interval_q};
    end else if (a == `RPX_CTRL) begin
      rd_d = 32'h0000_0000;
    end else if (a == `RPX_RSTSEL) begin
      rd_d = {26'h000_0000, reset_sel_q};
    end else if (a == `RPX_ONLINE) begin
      rd_d = {16'h0000, online_q};
    end else if (a == `RPX_RIN_VAL) begin
      rd_d = remote_in_q;
    end else if (a == `RPX_RIN_KNOWN) begin
      rd_d = known_q;
    end else if (a[11:5] == `RPX_DIRSRC_BASE >> 5) begin
      rd_d = direct_input_source_peer_q[a[4:2]];
    end else begin
      err_d = 1'b1;
    end
  end
  // APB handshake; a bad address answers with pslverr, writes dropped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup & err_d;
      if (setup && !pwrite) begin
        prdata <= rd_d;
      end
    end
  end

  // ----------------------------------------------------------------------
  // APB writes
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (k = 0; k < 80; k = k + 1) begin
        peer_slot_identifier_q[k] <= 32'h0000_0000;
        rin_cfg_q[k % 32] <= 12'h000;
        standard_point_source_q[k % 16] <= 32'h0000_0000;
        direct_input_source_peer_q[k % 8] <= 32'h0000_0000;
      end
      standard_point_log_enable_q <= 32'h0000_0000;
      interval_q <= `RPX_INTERVAL_RST;
      reset_sel_q <= 6'h00;
      comms_req_q <= 1'b0;
    end else begin
      comms_req_q <= 1'b0;
      if (wr_en) begin
        if (a < `RPX_ID_END) begin
          peer_slot_identifier_q[a[8:2]] <= pwdata;
        end else if (a[11:7] == `RPX_RIN_BASE >> 7) begin
          rin_cfg_q[a[6:2]] <= pwdata[11:0];
        end else if (a[11:6] == `RPX_TXSEL_BASE >> 6) begin
          standard_point_source_q[a[5:2]] <= pwdata;
        end else if (a == `RPX_LOGEN) begin
          standard_point_log_enable_q <= pwdata;
        end else if (a == `RPX_INTERVAL) begin
          interval_q <= pwdata[15:0];
        end else if (a == `RPX_CTRL) begin
          comms_req_q <= pwdata[`RPX_CTRL_COMMS_RST];
        end else if (a == `RPX_RSTSEL) begin
          reset_sel_q <= pwdata[5:0];
        end else if (a[11:5] == `RPX_DIRSRC_BASE >> 5) begin
          direct_input_source_peer_q[a[4:2]] <= pwdata;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Millisecond time base
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_q <= 17'h0_0000;
      ms_tick_q <= 1'b0;
    end else begin
      ms_tick_q <= (ms_cnt_q == MS_LAST);
      if (ms_cnt_q == MS_LAST) begin
        ms_cnt_q <= 17'h0_0000;
      end else begin
        ms_cnt_q <= ms_cnt_q + 17'h0_0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Receive: sender filter and hold timers
  // ----------------------------------------------------------------------
  wire [15:0] match;
  genvar s;
  generate
    for (s = 0; s < `RPX_SLOTS; s = s + 1) begin : g_slot
      reg [15:0] hold_q;
      // Full 160-bit compare; unused characters must be zero
      wire [159:0] sid = {peer_slot_identifier_q[s*5+4],
        peer_slot_identifier_q[s*5+3], peer_slot_identifier_q[s*5+2],
        peer_slot_identifier_q[s*5+1], peer_slot_identifier_q[s*5]};
      assign match[s] = msg_valid & (sid == msg_origin_id);
      // Arrival reloads; a miss of one message is tolerated by design
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          hold_q <= 16'h0000;
          online_q[s] <= 1'b0;
        end else if (match[s]) begin
          hold_q <= msg_hold_ms;
          online_q[s] <= 1'b1;
        end else if (ms_tick_q && hold_q != 16'h0000) begin
          hold_q <= hold_q - 16'h0001;
        end else if (ms_tick_q) begin
          online_q[s] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Remote inputs
  // ----------------------------------------------------------------------
  wire [127:0] msg_pairs = {msg_user, msg_dna};
  genvar i;
  generate
    for (i = 0; i < `RPX_POINTS; i = i + 1) begin : g_rin
      wire [3:0] dev = rin_cfg_q[i][`RPX_RIN_DEV_LSB +: 4];
      wire [5:0] sel = rin_cfg_q[i][`RPX_RIN_PAIR_LSB +: 6];
      wire [1:0] mode = rin_cfg_q[i][`RPX_RIN_MODE_LSB +: 2];
      wire [1:0] pair = msg_pairs[{sel, 1'b0} +: 2];
      wire upd = match[dev];
      // One message updates every input of its sender at once
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          remote_in_q[i] <= 1'b0;
          last_q[i] <= 1'b0;
          known_q[i] <= 1'b0;
        end else if (upd) begin
          remote_in_q[i] <= pair[1];
          last_q[i] <= pair[1];
          known_q[i] <= 1'b1;
        end else if (!online_q[dev]) begin
          // Fallback; startup counts as offline until first message
          case (mode)
            `RPX_MODE_OFF: remote_in_q[i] <= 1'b0;
            `RPX_MODE_ON: remote_in_q[i] <= 1'b1;
            `RPX_MODE_LATEST_OFF: begin
              remote_in_q[i] <= known_q[i] & last_q[i];
            end
            default: begin
              remote_in_q[i] <= ~known_q[i] | last_q[i];
            end
          endcase
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Transmit points
  // ----------------------------------------------------------------------
  // Point meaning comes from the chosen operand; the block moves bits
  wire [63:0] cur;
  genvar p;
  generate
    for (p = 0; p < 64; p = p + 1) begin : g_tx
      wire [5:0] src = standard_point_source_q[p/4][(p%4)*8 +: 6];
      assign cur[p] = local_operand[src];
    end
  endgenerate
  wire changed = (cur != {tx_user_q, tx_dna_q});
  wire due = (interval_q != 16'h0000) && (int_cnt_q >= interval_q);
  wire send = boot_q | changed | due;
  wire [31:0] hold_full = `RPX_HOLD_FACTOR * interval_q;

  // Send on power-up, on any change, or when the interval runs out
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_q <= 1'b1;
      tx_dna_q <= 32'h0000_0000;
      tx_user_q <= 32'h0000_0000;
      tx_send_q <= 1'b0;
      tx_hold_ms_q <= 18'h0_0000;
      int_cnt_q <= 16'h0000;
      dna_event_q <= 32'h0000_0000;
    end else begin
      boot_q <= 1'b0;
      tx_dna_q <= cur[31:0];
      tx_user_q <= cur[63:32];
      tx_send_q <= send;
      tx_hold_ms_q <= hold_full[17:0];
      dna_event_q <= (cur[31:0] ^ tx_dna_q) & standard_point_log_enable_q;
      if (send) begin
        int_cnt_q <= 16'h0000;
      end else if (ms_tick_q) begin
        int_cnt_q <= int_cnt_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Reset command sources and indicator latches
  // ----------------------------------------------------------------------
  wire oper_now = local_operand[reset_sel_q];
  wire panel_rise = panel_button & ~panel_prev_q;
  wire oper_rise = oper_now & ~oper_prev_q;
  // Each source pulses its own output and the common one
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      panel_prev_q <= 1'b0;
      oper_prev_q <= 1'b1; // Operand may idle high: no false edge
      panel_reset_pulse_q <= 1'b0;
      link_reset_pulse_q <= 1'b0;
      logic_reset_pulse_q <= 1'b0;
      common_reset_pulse_q <= 1'b0;
    end else begin
      panel_prev_q <= panel_button;
      oper_prev_q <= oper_now;
      panel_reset_pulse_q <= panel_rise;
      link_reset_pulse_q <= comms_req_q;
      logic_reset_pulse_q <= oper_rise;
      common_reset_pulse_q <= panel_rise | comms_req_q | oper_rise;
    end
  end
  // Set wins: a condition still present keeps its flag through reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latched_flag_q <= 32'h0000_0000;
    end else if (common_reset_pulse_q) begin
      latched_flag_q <= latch_cond;
    end else begin
      latched_flag_q <= latched_flag_q | latch_cond;
    end
  end

  // ----------------------------------------------------------------------
  // Direct inputs
  // ----------------------------------------------------------------------
  genvar d;
  generate
    for (d = 0; d < `RPX_POINTS; d = d + 1) begin : g_dir
      wire [7:0] srcp = direct_input_source_peer_q[d/4][(d%4)*8 +: 8];
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          direct_in_q[d] <= 1'b0;
        end else if (dir_valid && dir_peer == srcp) begin
          direct_in_q[d] <= dir_bits[d];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// File: dv/rpx_chk.sv
// Purpose: Port assertions for the remote point exchange block.
// Assumes: Zero wait APB slave, registered one-cycle pulses.
// Notes:   Bound into every instance of the block.
`timescale 1ns/10ps
`default_nettype none
`include "rpx_map.vh"
module rpx_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic panel_button,
  input wire logic [31:0] latch_cond,
  input wire logic [31:0] latched_flag_q,
  input wire logic common_reset_pulse_q,
  input wire logic panel_reset_pulse_q,
  input wire logic link_reset_pulse_q,
  input wire logic logic_reset_pulse_q,
  input wire logic [31:0] tx_dna_q,
  input wire logic tx_send_q
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus phases and the comms reset write
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_ctrl_wr;
    psel && penable && pready && pwrite && paddr == `RPX_CTRL && pwdata[0];
  endsequence
  sequence s_quiet;
    !common_reset_pulse_q ##1 !common_reset_pulse_q;
  endsequence
  // Answer comes in the cycle after setup, for one cycle only
  chk_apb_answer: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
  chk_apb_single: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // Reset command sources
  chk_panel_pulse: assert property ($rose(panel_button) |=>
    panel_reset_pulse_q && common_reset_pulse_q)
    else $error("panel command gave no pulses");
  chk_link_pulse: assert property (s_ctrl_wr |-> ##2
    link_reset_pulse_q && common_reset_pulse_q)
    else $error("comms command gave no pulses");
  chk_src_common: assert property ((panel_reset_pulse_q ||
    link_reset_pulse_q || logic_reset_pulse_q) |-> common_reset_pulse_q)
    else $error("source pulse without common pulse");
  // Latches hold without a command, clear to live conditions with one
  chk_latch_hold: assert property (s_quiet |->
    (latched_flag_q & $past(latched_flag_q)) == $past(latched_flag_q))
    else $error("latched flag dropped without command");
  chk_latch_clear: assert property (common_reset_pulse_q |->
    ##[0:1] latched_flag_q == $past(latch_cond))
    else $error("flags not reduced to live conditions");
  // A changed point is sent at once
  chk_send_change: assert property (tx_dna_q != $past(tx_dna_q)
    |-> tx_send_q)
    else $error("point change without send");
endmodule
bind rpx_remote_point_exchange rpx_chk rpx_chk_i (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .panel_button,
  .latch_cond, .latched_flag_q, .common_reset_pulse_q, .panel_reset_pulse_q,
  .link_reset_pulse_q, .logic_reset_pulse_q, .tx_dna_q, .tx_send_q);
`default_nettype wire

// File: dv/rpx_peer.sv
// Purpose: Peer relay sending one status message per request.
// Assumes: Request is a one-cycle level from the bench.
// Notes:   Idle lines wander so stale contents never look valid.
`timescale 1ns/10ps
`default_nettype none
module rpx_peer (
  input wire logic pclk,
  input wire logic req,
  input wire logic [159:0] req_id,
  input wire logic [63:0] req_dna,
  input wire logic [63:0] req_user,
  input wire logic [15:0] req_hold,
  output logic msg_valid,
  output logic [159:0] msg_origin_id,
  output logic [63:0] msg_dna,
  output logic [63:0] msg_user,
  output logic [15:0] msg_hold_ms
);
  initial begin
    msg_valid = 1'b0;
    {msg_origin_id, msg_dna, msg_user, msg_hold_ms} = '0;
  end
  // Peer is available and in normal mode; other points pass as asked
  always @(posedge pclk) begin
    msg_valid <= req;
    if (req) begin
      msg_origin_id <= req_id;
      msg_dna <= {req_dna[63:54], 2'b00, req_dna[51:42], 2'b11,
        req_dna[39:0]};
      msg_user <= req_user;
      msg_hold_ms <= req_hold;
    end else begin
      {msg_origin_id, msg_dna, msg_user, msg_hold_ms} <=
        ~{msg_origin_id, msg_dna, msg_user, msg_hold_ms};
    end
  end
endmodule
`default_nettype wire

// File: dv/rpx_remote_point_exchange_tb.sv
// Purpose: Self-checking bench for the remote point exchange block.
// Assumes: Millisecond prescaler shortened to 10 cycles.
// Notes:   Remote inputs checked against a model of slots 1 and 6.
`timescale 1ns/10ps
`default_nettype none
`include "rpx_map.vh"
module rpx_remote_point_exchange_tb;
  typedef struct packed {int who; logic [63:0] d; logic [63:0] u;} rpx_row_t;
  localparam logic [159:0] ID0 = {20{8'h41}};
  localparam logic [159:0] ID5 = {20{8'h42}};
  localparam logic [159:0] IDX = {8'h43, {19{8'h41}}};
  localparam logic [63:0] OP = 64'h1234_5678_9ABC_DE0F;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, panel_button = 1'b0, dir_valid = 1'b0, req = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, latch_cond = '0, dir_bits = '0, rd_q, err_q;
  logic [63:0] local_operand = '0, req_dna = '0, req_user = '0;
  logic [159:0] req_id = '0, msg_origin_id;
  logic [15:0] req_hold = '0, msg_hold_ms;
  logic [7:0] dir_peer = '0;
  logic [63:0] msg_dna, msg_user;
  logic [31:0] prdata, remote_in_q, tx_dna_q, tx_user_q, dna_event_q;
  logic [31:0] latched_flag_q, direct_in_q, last = '0, known = '0;
  logic [17:0] tx_hold_ms_q;
  logic [15:0] onl = '0;
  logic [3:0] p;
  logic pready, pslverr, msg_valid, tx_send_q, common_reset_pulse_q;
  logic panel_reset_pulse_q, link_reset_pulse_q, logic_reset_pulse_q;
  int num_errors = 0, compares = 0;
  rpx_row_t rows [5] = '{'{0, 64'hFFFF_FFFF_FFFF_FFFF, 64'h0},
    '{1, 64'h0, 64'hFFFF_FFFF_FFFF_FFFF}, '{2, 64'h0, 64'h0},
    '{0, 64'hAAAA_AAAA_AAAA_AAAA, 64'h5555_5555_5555_5555},
    '{1, 64'h3333_3333_3333_3333, 64'hCCCC_CCCC_CCCC_CCCC}};
  rpx_remote_point_exchange #(.MS_CYCLES(10)) rpx_remote_point_exchange_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .msg_valid, .msg_origin_id, .msg_dna, .msg_user,
    .msg_hold_ms, .remote_in_q, .local_operand, .tx_dna_q, .tx_user_q,
    .tx_hold_ms_q, .tx_send_q, .dna_event_q, .panel_button, .latch_cond,
    .latched_flag_q, .common_reset_pulse_q, .panel_reset_pulse_q,
    .link_reset_pulse_q, .logic_reset_pulse_q, .dir_valid, .dir_peer,
    .dir_bits, .direct_in_q);
  rpx_peer rpx_peer_i (.pclk, .req, .req_id, .req_dna, .req_user, .req_hold,
    .msg_valid, .msg_origin_id, .msg_dna, .msg_user, .msg_hold_ms);
  // 100 MHz clock
  always #5 pclk = ~pclk;
  task end_sim;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; the bus is idle for a cycle before each setup
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd_q = prdata;
    err_q = {31'h0, pslverr};
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      end_sim();
    end
  endtask
  // Expected remote inputs: even ones from slot 1, odd ones from slot 6
  function automatic logic [31:0] exp_in();
    logic [31:0] r;
    for (int i = 0; i < 32; i++) begin
      if (onl[(i % 2) * 5])
        r[i] = last[i];
      else
        case ((i / 2) % 4)
          0: r[i] = 1'b0;
          1: r[i] = 1'b1;
          2: r[i] = known[i] & last[i];
          default: r[i] = !known[i] | last[i];
        endcase
    end
    return r;
  endfunction
  // Message through the peer, then the model follows the upper bits
  task send(input int who, input logic [63:0] d, input logic [63:0] u,
      input logic [15:0] h);
    logic [63:0] e;
    e = d;
    e[41:40] = 2'b11;
    e[53:52] = 2'b00;
    req_id <= who == 0 ? ID0 : who == 1 ? ID5 : IDX;
    req_dna <= d;
    req_user <= u;
    req_hold <= h;
    req <= 1'b1;
    @(posedge pclk);
    req <= 1'b0;
    if (who < 2) begin
      onl[who * 5] = 1'b1;
      for (int i = who; i < 32; i += 2) begin
        last[i] = i % 2 ? u[2 * i + 1] : e[2 * i + 1];
        known[i] = 1'b1;
      end
    end
    repeat (4) @(posedge pclk);
  endtask
  // Collect the reset pulses seen over a few cycles
  task watch;
    p = 4'h0;
    repeat (5) begin
      @(posedge pclk);
      p = p | {common_reset_pulse_q, panel_reset_pulse_q,
        link_reset_pulse_q, logic_reset_pulse_q};
    end
  endtask
  initial begin
    logic [31:0] d;
    logic [31:0] eu;
    int n;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `RPX_INTERVAL, 0);
    cmp("interval", {16'h0, `RPX_INTERVAL_RST}, rd_q);
    cmp("hold", 32'h0000_0BB8, {14'h0, tx_hold_ms_q});
    for (int w = 0; w < 5; w++) begin
      apb(1, 12'(w * 4), ID0[32 * w +: 32]);
      apb(1, 12'((25 + w) * 4), ID5[32 * w +: 32]);
    end
    for (int i = 0; i < 32; i++)
      apb(1, 12'(`RPX_RIN_BASE + 4 * i), 32'((i / 2 % 4) << 10 |
        (i % 2 ? 32 + i : i) << 4 | (i % 2) * 5));
    repeat (3) @(posedge pclk);
    cmp("startup", exp_in(), remote_in_q);
    foreach (rows[k]) begin
      send(rows[k].who, rows[k].d, rows[k].u, 16'd8);
      cmp("remote_in", exp_in(), remote_in_q);
    end
    // Slot 1 falls silent while slot 6 stays fresh
    send(1, 64'h0, 64'h0F0F_0F0F_0F0F_0F0F, 16'd8);
    send(0, 64'h0F0F_0F0F_0F0F_0F0F, 64'h0, 16'd1);
    repeat (40) @(posedge pclk);
    onl[0] = 1'b0;
    cmp("frozen", exp_in(), remote_in_q);
    apb(0, `RPX_ONLINE, 0);
    cmp("online", 32'h0000_0020, rd_q);
    send(0, 64'hFFFF_FFFF_FFFF_FFFF, 64'h0, 16'd8);
    cmp("resumed", exp_in(), remote_in_q);
    // Transmit selection: standard point p from operand p, user from 63-p
    for (int r = 0; r < 16; r++) begin
      for (int j = 0; j < 4; j++)
        d[8 * j +: 8] = 8'(r < 8 ? 4 * r + j : 95 - 4 * r - j);
      apb(1, 12'(`RPX_TXSEL_BASE + 4 * r), d);
    end
    local_operand <= OP;
    repeat (3) @(posedge pclk);
    for (int q = 0; q < 32; q++)
      eu[q] = OP[63 - q];
    cmp("tx_dna", OP[31:0], tx_dna_q);
    cmp("tx_user", eu, tx_user_q);
    apb(1, `RPX_INTERVAL, 32'h0000_0002);
    n = 0;
    repeat (100) begin
      @(posedge pclk);
      n += tx_send_q;
    end
    cmp("resends", 32'h1, {31'h0, n >= 4 && n <= 6});
    cmp("hold", 32'h0000_0006, {14'h0, tx_hold_ms_q});
    // Latches and the three reset sources
    apb(1, `RPX_RSTSEL, 32'h0000_0005);
    latch_cond <= 32'h0000_0018;
    @(posedge pclk);
    latch_cond <= 32'h0000_0010;
    repeat (3) @(posedge pclk);
    cmp("flags", 32'h0000_0018, latched_flag_q);
    panel_button <= 1'b1;
    watch();
    cmp("panel", 32'h0000_000C, {28'h0, p});
    cmp("flags", 32'h0000_0010, latched_flag_q);
    panel_button <= 1'b0;
    apb(1, `RPX_CTRL, 32'h0000_0001);
    watch();
    cmp("comms", 32'h0000_000A, {28'h0, p});
    local_operand[5] <= 1'b1;
    watch();
    cmp("operand", 32'h0000_0009, {28'h0, p});
    // Only the logged standard point 6 reports its change
    apb(1, `RPX_LOGEN, 32'h0000_0020);
    local_operand[5] <= 1'b0;
    d = 32'h0000_0000;
    repeat (4) begin
      @(posedge pclk);
      d = d | dna_event_q;
    end
    cmp("dna_event", 32'h0000_0020, d);
    // Direct inputs 1 and 2 take peers 7 and 9
    apb(1, `RPX_DIRSRC_BASE, 32'h0000_0907);
    dir_peer <= 8'h07;
    dir_bits <= 32'hFFFF_FFFF;
    dir_valid <= 1'b1;
    @(posedge pclk);
    dir_valid <= 1'b0;
    repeat (2) @(posedge pclk);
    cmp("direct", 32'h0000_0001, direct_in_q);
    apb(0, 12'h3F0, 0);
    cmp("unmapped err", 32'h0000_0001, err_q);
    cmp("unmapped data", 32'h0000_0000, rd_q);
    // Mid-run resets: flags clear, power-up send, no false command edge
    for (int t = 0; t < 2; t++) begin
      local_operand <= 64'(t);
      presetn <= 1'b0;
      @(posedge pclk);
      cmp("reset flags", 32'h0000_0000, latched_flag_q);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      cmp("power-up send", 32'h1, {31'h0, tx_send_q});
      cmp("reset pulse", 32'h0, {31'h0, common_reset_pulse_q});
    end
    end_sim();
  end
endmodule
`default_nettype wire
